// file: hdl/alarm_pkg.sv
// Purpose: Shared constants and types for the servo alarm manager.
// Assumes: Registers are 32-bit words on a classic Wishbone slave.
// Notes: Alarm codes are shown as plain binary numbers on alarm_code.
package alarm_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DEV_THRESH = 8'h08;
    localparam logic [7:0] OFS_GEAR = 8'h0C;
    localparam logic [7:0] OFS_SPEED_LIMIT = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // Field positions.
    localparam int CTRL_OP_RESET_BIT = 0;
    localparam int IRQ_RAISED_BIT = 0;
    localparam int IRQ_CLEARED_BIT = 1;
    localparam int GEAR_NUM_LSB = 0;
    localparam int GEAR_DEN_LSB = 16;

    // Reset values.
    localparam logic [31:0] DEV_THRESH_RST = 32'h0001_0000;
    localparam logic [15:0] GEAR_NUM_RST = 16'h0001;
    localparam logic [15:0] GEAR_DEN_RST = 16'h0001;
    localparam logic [15:0] SPEED_LIMIT_RST = 16'h1770;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // Largest accepted gear ratio in either direction.
    localparam logic [15:0] GEAR_RATIO_LIMIT = 16'h0032;

    // Fault source indices.
    localparam int NUM_FAULTS = 6;
    localparam logic [2:0] IDX_UNDERVOLT = 3'h0;
    localparam logic [2:0] IDX_DEVIATION = 3'h1;
    localparam logic [2:0] IDX_OVERSPEED = 3'h2;
    localparam logic [2:0] IDX_GEAR = 3'h3;
    localparam logic [2:0] IDX_ENC_AB = 3'h4;
    localparam logic [2:0] IDX_ENC_SERIAL = 3'h5;

    // Displayed alarm codes, 13, 24, 26, 27, 45 and 49.
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_UNDERVOLT = 8'h0D;
    localparam logic [7:0] CODE_DEVIATION = 8'h18;
    localparam logic [7:0] CODE_OVERSPEED = 8'h1A;
    localparam logic [7:0] CODE_GEAR = 8'h1B;
    localparam logic [7:0] CODE_ENC_AB = 8'h2D;
    localparam logic [7:0] CODE_ENC_SERIAL = 8'h31;

    // Sources that a reset input or operator reset may clear.
    localparam logic [5:0] RESETTABLE_MASK = 6'h0F;

    // Alarm manager states.
    typedef enum logic {
        ST_RUN = 1'b0,
        ST_ALARM = 1'b1
    } alarm_state_e;

    // Detector settings.
    typedef struct packed {
        logic [31:0] dev_thresh;
        logic [15:0] gear_num;
        logic [15:0] gear_den;
        logic [15:0] speed_limit;
    } detect_cfg_s;

    // Raw process measurements.
    typedef struct packed {
        logic undervolt;
        logic [31:0] deviation_count;
        logic [15:0] motor_speed;
        logic enc_ab_error;
        logic encoder_serial_frame_error;
    } sense_s;

endpackage

// file: hdl/alarm_detect.sv
// Purpose: Combinational fault condition detectors.
// Assumes: Measurements are already synchronous to clk.
// Notes: Conditions are live levels; latching is done by the caller.
`timescale 1ns/1ns
module alarm_detect (
    // Settings and measurements
    input wire alarm_pkg::detect_cfg_s cfg,
    input wire alarm_pkg::sense_s sense,
    // Live conditions, one per fault source
    output wire logic [alarm_pkg::NUM_FAULTS-1:0] cond
);

    // Scaled sides of the gear ratio, wide enough for the product.
    wire logic [31:0] num_scaled;
    wire logic [31:0] den_scaled;
    wire logic gear_bad;

    // Ratio bounds checked both ways so that neither side may dominate.
    assign num_scaled = 32'(cfg.gear_num) * 32'(alarm_pkg::GEAR_RATIO_LIMIT);
    assign den_scaled = 32'(cfg.gear_den) * 32'(alarm_pkg::GEAR_RATIO_LIMIT);
    assign gear_bad = (cfg.gear_num == 16'h0000) || (cfg.gear_den == 16'h0000) ||
                      (32'(cfg.gear_num) > den_scaled) || (32'(cfg.gear_den) > num_scaled);

    assign cond[alarm_pkg::IDX_UNDERVOLT] = sense.undervolt;
    assign cond[alarm_pkg::IDX_DEVIATION] = sense.deviation_count > cfg.dev_thresh;
    assign cond[alarm_pkg::IDX_OVERSPEED] = sense.motor_speed > cfg.speed_limit;
    assign cond[alarm_pkg::IDX_GEAR] = gear_bad;
    assign cond[alarm_pkg::IDX_ENC_AB] = sense.enc_ab_error;
    assign cond[alarm_pkg::IDX_ENC_SERIAL] = sense.encoder_serial_frame_error;

endmodule // alarm_detect

// file: hdl/servo_alarm_manager.sv
// Purpose: Latches drive faults, shows the alarm code and gates the power stage.
// Assumes: One 25 MHz clock; rst_b is the power-on reset, so a power cycle resets it.
// Notes: Registers are reached over a classic Wishbone slave with one wait state.
`timescale 1ns/1ns
module servo_alarm_manager #(
    parameter int ADDR_W = 8
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,

    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // Controller inputs
    input wire logic run_cmd,
    input wire logic alarm_reset_in,

    // Process measurements
    input wire logic undervolt,
    input wire logic [31:0] deviation_count,
    input wire logic [15:0] motor_speed,
    input wire logic enc_ab_error,
    input wire logic encoder_serial_frame_error,

    // Drive outputs
    output logic fault_output,
    output logic power_stage_en,
    output logic [7:0] alarm_code,
    output logic irq
);

    // Elaboration check: the map needs at least byte offsets up to 0x18.
    // Upper address bits are ignored, so the map repeats.
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    // The source priority below is written for six faults.
    if (alarm_pkg::NUM_FAULTS != 6) begin : g_fault_check
        $error("NUM_FAULTS must be 6");
    end

    // State and register storage.
    alarm_pkg::alarm_state_e state_q, state_d;
    logic [7:0] code_q, code_d;
    logic [2:0] idx_q, idx_d;
    logic reset_in_q;

    // Settings registers.
    logic [31:0] dev_thresh_q;
    logic [15:0] gear_num_q;
    logic [15:0] gear_den_q;
    logic [15:0] speed_limit_q;

    // Interrupt and bus answer registers.
    logic [1:0] irq_status_q, irq_status_d;
    logic [1:0] irq_mask_q;
    logic ack_q;
    logic [31:0] rdata_q;

    // Drive output registers.
    logic fault_q;
    logic power_q;
    logic [7:0] shown_q;
    logic irq_q;

    // Detector carriers.
    alarm_pkg::detect_cfg_s cfg;
    alarm_pkg::sense_s sense;
    logic [alarm_pkg::NUM_FAULTS-1:0] cond;

    // Bus decode wires.
    wire logic bus_req;
    wire logic bus_wr;
    wire logic [7:0] adr;
    wire logic hit_ctrl;
    wire logic hit_status;
    wire logic hit_dev;
    wire logic hit_gear;
    wire logic hit_speed;
    wire logic hit_irq_status;
    wire logic hit_irq_mask;

    // Write mask and read path.
    wire logic [31:0] wmask;
    wire logic [31:0] status_word;
    wire logic [31:0] rdata_d;

    // Alarm decision wires.
    wire logic any_cond;
    wire logic [2:0] new_idx;
    wire logic [7:0] new_code;
    wire logic op_reset;
    wire logic clear_req;
    wire logic cause_gone;
    wire logic clear_ok;
    wire logic raise;

    // Interrupt wires.
    wire logic [1:0] irq_event;
    wire logic [1:0] irq_w1c;

    // Gather settings and measurements for the detector.
    assign cfg.dev_thresh = dev_thresh_q;
    assign cfg.gear_num = gear_num_q;
    assign cfg.gear_den = gear_den_q;
    assign cfg.speed_limit = speed_limit_q;

    // Measurements are used as they arrive.
    assign sense.undervolt = undervolt;
    assign sense.deviation_count = deviation_count;
    assign sense.motor_speed = motor_speed;
    assign sense.enc_ab_error = enc_ab_error;
    assign sense.encoder_serial_frame_error = encoder_serial_frame_error;

    alarm_detect u_detect (
        .cfg(cfg),
        .sense(sense),
        .cond(cond)
    );

    // Bus request is taken once per cycle; ack_q blocks a second take.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr = bus_req && wb_we_i;
    assign adr = {wb_adr_i[7:2], 2'h0};

    // Register select; low address bits are ignored.
    assign hit_ctrl = adr == alarm_pkg::OFS_CTRL;
    assign hit_status = adr == alarm_pkg::OFS_STATUS;
    assign hit_dev = adr == alarm_pkg::OFS_DEV_THRESH;
    assign hit_gear = adr == alarm_pkg::OFS_GEAR;
    assign hit_speed = adr == alarm_pkg::OFS_SPEED_LIMIT;
    assign hit_irq_status = adr == alarm_pkg::OFS_IRQ_STATUS;
    assign hit_irq_mask = adr == alarm_pkg::OFS_IRQ_MASK;

    // Byte enables widened to a bit mask, one lane per generate pass.
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    // Status word: state, resettable flag, run and power stage, code.
    // Bit 10 reads one when idle, as the idle index is resettable.
    assign status_word = {16'h0000, 4'h0, state_q == alarm_pkg::ST_ALARM,
                          alarm_pkg::RESETTABLE_MASK[idx_q], run_cmd, power_q, code_q};

    // Read multiplexer; unmapped offsets read as zero.
    assign rdata_d = hit_status ? status_word :
                     hit_dev ? dev_thresh_q :
                     hit_gear ? {gear_den_q, gear_num_q} :
                     hit_speed ? {16'h0000, speed_limit_q} :
                     hit_irq_status ? {30'h0000_0000, irq_status_q} :
                     hit_irq_mask ? {30'h0000_0000, irq_mask_q} :
                     32'h0000_0000;

    // Highest priority goes to the non-resettable encoder faults.
    // Ties between faults resolve by this fixed order.
    assign any_cond = |cond;
    assign new_idx = cond[alarm_pkg::IDX_ENC_AB] ? alarm_pkg::IDX_ENC_AB :
                     cond[alarm_pkg::IDX_ENC_SERIAL] ? alarm_pkg::IDX_ENC_SERIAL :
                     cond[alarm_pkg::IDX_UNDERVOLT] ? alarm_pkg::IDX_UNDERVOLT :
                     cond[alarm_pkg::IDX_DEVIATION] ? alarm_pkg::IDX_DEVIATION :
                     cond[alarm_pkg::IDX_OVERSPEED] ? alarm_pkg::IDX_OVERSPEED :
                     alarm_pkg::IDX_GEAR;

    // Code lookup for the chosen source.
    assign new_code = (new_idx == alarm_pkg::IDX_ENC_AB) ? alarm_pkg::CODE_ENC_AB :
                      (new_idx == alarm_pkg::IDX_ENC_SERIAL) ? alarm_pkg::CODE_ENC_SERIAL :
                      (new_idx == alarm_pkg::IDX_UNDERVOLT) ? alarm_pkg::CODE_UNDERVOLT :
                      (new_idx == alarm_pkg::IDX_DEVIATION) ? alarm_pkg::CODE_DEVIATION :
                      (new_idx == alarm_pkg::IDX_OVERSPEED) ? alarm_pkg::CODE_OVERSPEED :
                      alarm_pkg::CODE_GEAR;

    // The bit has no storage, so writing zero does nothing.
    // Operator reset strobe.
    assign op_reset = bus_wr && hit_ctrl && wb_sel_i[0] && wb_dat_i[alarm_pkg::CTRL_OP_RESET_BIT];
    // Reset input edge.
    // Only the rising edge acts, so a held reset cannot mask a fresh fault.
    assign clear_req = (alarm_reset_in && !reset_in_q) || op_reset;
    // Only the latched source must be gone.
    assign cause_gone = !cond[idx_q];
    assign clear_ok = (state_q == alarm_pkg::ST_ALARM) && clear_req && cause_gone &&
                      alarm_pkg::RESETTABLE_MASK[idx_q];

    // A fault in run state latches at the next edge.
    assign raise = (state_q == alarm_pkg::ST_RUN) && any_cond;

    // Interrupt events and write-one-to-clear bits.
    assign irq_event = {clear_ok, raise};
    assign irq_w1c = (bus_wr && hit_irq_status && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

    // Alarm latch state machine.
    always_comb begin
        state_d = state_q;
        code_d = code_q;
        idx_d = idx_q;

        unique case (state_q)
            alarm_pkg::ST_RUN: begin
                if (any_cond) begin
                    state_d = alarm_pkg::ST_ALARM;
                    code_d = new_code;
                    idx_d = new_idx;
                end
            end

            alarm_pkg::ST_ALARM: begin
                // Later faults are ignored; the first code is kept.
                // Hold until cleared.
                if (clear_ok) begin
                    state_d = alarm_pkg::ST_RUN;
                    code_d = alarm_pkg::CODE_NONE;
                    idx_d = alarm_pkg::IDX_UNDERVOLT;
                end
            end
        endcase
    end

    // A new event wins over a clear written in the same cycle.
    always_comb begin
        irq_status_d = (irq_status_q & ~irq_w1c) | irq_event;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= alarm_pkg::ST_RUN;
            code_q <= alarm_pkg::CODE_NONE;
            idx_q <= alarm_pkg::IDX_UNDERVOLT;
            reset_in_q <= 1'b0;
        end else begin
            state_q <= state_d;
            code_q <= code_d;
            idx_q <= idx_d;
            // Runs in both states, so a held input never looks new.
            reset_in_q <= alarm_reset_in;
        end
    end

    // Drive outputs registered from the next state, so no cycle is lost.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_q <= 1'b0;
            power_q <= 1'b0;
            shown_q <= alarm_pkg::CODE_NONE;
        end else begin
            fault_q <= state_d == alarm_pkg::ST_ALARM;
            shown_q <= code_d;

            // Immediate restart on run.
            // The stage follows run as a level; no fresh run edge is awaited.
            power_q <= run_cmd && (state_d == alarm_pkg::ST_RUN);
        end
    end

    // Settings registers with byte-lane writes.
    // CTRL and STATUS keep nothing from a write.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dev_thresh_q <= alarm_pkg::DEV_THRESH_RST;
            gear_num_q <= alarm_pkg::GEAR_NUM_RST;
            gear_den_q <= alarm_pkg::GEAR_DEN_RST;
            speed_limit_q <= alarm_pkg::SPEED_LIMIT_RST;
            irq_mask_q <= alarm_pkg::IRQ_MASK_RST;
        end else if (bus_wr) begin
            if (hit_dev) begin
                dev_thresh_q <= (dev_thresh_q & ~wmask) | (wb_dat_i & wmask);
            end

            if (hit_gear) begin
                gear_num_q <= (gear_num_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                gear_den_q <= (gear_den_q & ~wmask[31:16]) | (wb_dat_i[31:16] & wmask[31:16]);
            end

            if (hit_speed) begin
                speed_limit_q <= (speed_limit_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            end

            if (hit_irq_mask && wb_sel_i[0]) begin
                irq_mask_q <= wb_dat_i[1:0];
            end
        end
    end

    // Interrupt status and the level output.
    // The mask uses its old value in the cycle it is written.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_q <= |(irq_status_d & irq_mask_q);
        end
    end

    // Bus answer: ack one cycle after the request, then drop for a cycle.
    // Read data holds until the next request is taken.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Top outputs straight from flip-flops.
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    assign fault_output = fault_q;
    assign power_stage_en = power_q;
    assign alarm_code = shown_q;
    assign irq = irq_q;

endmodule // servo_alarm_manager

// file: bench/alarm_checker.sv
// Purpose: Concurrent checks on the alarm manager ports.
// Assumes: One clock; rst_b is the asynchronous power-on reset.
// Notes: Bound to every instance of the alarm manager.
`timescale 1ns/1ns
module alarm_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Controller and sensing
    input wire logic run_cmd,
    input wire logic alarm_reset_in,
    input wire logic undervolt,
    input wire logic enc_ab_error,
    input wire logic encoder_serial_frame_error,
    // Drive outputs
    input wire logic fault_output,
    input wire logic power_stage_en,
    input wire logic [7:0] alarm_code
);
    // Reset disables all checks, since a power cycle may clear anything.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    fault_power_a: assert property (fault_output |-> !power_stage_en)
        else $error("power stage on during alarm");
    code_match_a: assert property (fault_output == (alarm_code != 8'h00))
        else $error("alarm code and fault output disagree");
    code_hold_a: assert property (fault_output && $past(fault_output) |-> $stable(alarm_code))
        else $error("alarm code changed while latched");
    undervolt_a: assert property (!fault_output && undervolt
        && !enc_ab_error && !encoder_serial_frame_error |=> alarm_code == 8'h0D)
        else $error("undervoltage code missing");
    enc_ab_a: assert property (!fault_output && enc_ab_error |=> alarm_code == 8'h2D)
        else $error("quadrature code missing");
    locked_a: assert property (fault_output && (alarm_code == 8'h2D || alarm_code == 8'h31)
        |=> fault_output)
        else $error("locked alarm released");
    pin_clear_a: assert property (fault_output && alarm_code == 8'h0D && !undervolt
        && $rose(alarm_reset_in) |=> !fault_output)
        else $error("reset input did not clear");
    run_follow_a: assert property (!fault_output |-> power_stage_en == $past(run_cmd))
        else $error("power stage does not follow run");
    // A taken request is answered in exactly one cycle, and only once.
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer late or long");
endmodule // alarm_checker

bind servo_alarm_manager alarm_checker u_alarm_checker (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .run_cmd(run_cmd), .alarm_reset_in(alarm_reset_in), .undervolt(undervolt), .enc_ab_error(enc_ab_error),
    .encoder_serial_frame_error(encoder_serial_frame_error), .fault_output(fault_output),
    .power_stage_en(power_stage_en), .alarm_code(alarm_code)
);

// file: bench/drive_side_model.sv
// Purpose: Controller, encoder and power-stage side of the alarm manager.
// Assumes: Steered by tb tasks; every change follows a rising edge.
// Notes: Sense lines are levels, held until a task sets or releases them.
`timescale 1ns/1ns
module drive_side_model (
    // Clock
    input wire logic clk,
    // Controller lines
    output logic run_cmd,
    output logic alarm_reset_in,
    // Measurements
    output alarm_pkg::sense_s sense
);
    // Idle values keep every measurement in its safe range.
    initial begin
        run_cmd = 1'b0;
        alarm_reset_in = 1'b0;
        sense = '0;
    end
    // Raises or removes one fault cause; the gear fault lives in a register.
    task automatic cause(input logic [2:0] idx, input logic on);
        @(posedge clk);
        case (idx)
            alarm_pkg::IDX_UNDERVOLT: sense.undervolt <= on;
            alarm_pkg::IDX_DEVIATION: sense.deviation_count <= on ? alarm_pkg::DEV_THRESH_RST + 32'h1 : 32'h0;
            alarm_pkg::IDX_OVERSPEED: sense.motor_speed <= on ? alarm_pkg::SPEED_LIMIT_RST + 16'h1 : 16'h0;
            alarm_pkg::IDX_ENC_AB: sense.enc_ab_error <= on;
            alarm_pkg::IDX_ENC_SERIAL: sense.encoder_serial_frame_error <= on;
            default: ;
        endcase
    endtask
    // Sets the deviation count to an exact figure.
    task automatic set_dev(input logic [31:0] v);
        @(posedge clk);
        sense.deviation_count <= v;
    endtask
    // Sets the run command level.
    task automatic set_run(input logic on);
        @(posedge clk);
        run_cmd <= on;
    endtask
    // Run dropped first unless keep_run is set.
    // The pulse lasts two cycles so its rising edge is seen whatever the phase.
    task automatic pulse_reset(input logic keep_run);
        @(posedge clk);
        run_cmd <= run_cmd & keep_run;
        @(posedge clk);
        alarm_reset_in <= 1'b1;
        repeat (2) @(posedge clk);
        alarm_reset_in <= 1'b0;
    endtask
endmodule // drive_side_model

// file: bench/tb.sv
// Purpose: Self-checking bench for the servo alarm manager.
// Assumes: 25 MHz clock; registers reached by a classic Wishbone master.
// Notes: Every alarm source runs from a table; awkward cases follow by hand.
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic [2:0] idx; logic [7:0] code; logic res;} row_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic run_cmd;
    logic alarm_reset_in;
    alarm_pkg::sense_s sense;
    logic fault_output;
    logic power_stage_en;
    logic [7:0] alarm_code;
    logic irq;
    logic [31:0] rd;
    int n_errors = 0;
    int n_checks = 0;
    // Source, shown code and whether a reset may clear it.
    row_s rows [6] = '{'{alarm_pkg::IDX_UNDERVOLT, 8'h0D, 1'b1}, '{alarm_pkg::IDX_DEVIATION, 8'h18, 1'b1},
        '{alarm_pkg::IDX_OVERSPEED, 8'h1A, 1'b1}, '{alarm_pkg::IDX_GEAR, 8'h1B, 1'b1},
        '{alarm_pkg::IDX_ENC_AB, 8'h2D, 1'b0}, '{alarm_pkg::IDX_ENC_SERIAL, 8'h31, 1'b0}};

    // A 40 ns clock.
    always #20 clk = ~clk;

    servo_alarm_manager u_servo_alarm_manager (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .run_cmd(run_cmd), .alarm_reset_in(alarm_reset_in),
        .undervolt(sense.undervolt), .deviation_count(sense.deviation_count),
        .motor_speed(sense.motor_speed), .enc_ab_error(sense.enc_ab_error),
        .encoder_serial_frame_error(sense.encoder_serial_frame_error), .fault_output(fault_output),
        .power_stage_en(power_stage_en), .alarm_code(alarm_code), .irq(irq)
    );
    drive_side_model ctrl (.clk(clk), .run_cmd(run_cmd), .alarm_reset_in(alarm_reset_in), .sense(sense));

    // Compares of flags and of words; case inequality lets no unknown pass.
    task automatic chk_b(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_w(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic cycle, held until ack is sampled; read data lands in rd.
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        chk_b("bus ack", 1'b1, wb_ack_o);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // Waits n edges and lets their updates settle.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Power off and on again, with run already low.
    task automatic power_cycle();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole run needs a few hundred cycles; this is far beyond that.
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        // Setting reset values, an unmapped read and a write to read-only status.
        bus(1'b0, alarm_pkg::OFS_DEV_THRESH, 32'h0);
        chk_w("threshold", 32'h0001_0000, rd);
        bus(1'b0, alarm_pkg::OFS_GEAR, 32'h0);
        chk_w("gear", 32'h0001_0001, rd);
        bus(1'b0, alarm_pkg::OFS_SPEED_LIMIT, 32'h0);
        chk_w("speed limit", 32'h0000_1770, rd);
        bus(1'b0, 8'h1C, 32'h0);
        chk_w("unmapped", 32'h0, rd);
        bus(1'b1, alarm_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, alarm_pkg::OFS_STATUS, 32'h0);
        chk_w("status idle", 32'h0, rd & 32'hFFFF_FBFF);
        // Each source: raise, hold after the cause goes, then clear as its class allows.
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, alarm_pkg::OFS_IRQ_MASK, 32'h3);
            if (rows[i].idx == alarm_pkg::IDX_GEAR) begin
                bus(1'b1, alarm_pkg::OFS_GEAR, 32'h0001_0000);
            end else begin
                ctrl.cause(rows[i].idx, 1'b1);
            end
            tick(3);
            chk_b("fault", 1'b1, fault_output);
            chk_b("power stage", 1'b0, power_stage_en);
            chk_w("code", {24'h0, rows[i].code}, {24'h0, alarm_code});
            chk_b("irq raised", 1'b1, irq);
            bus(1'b0, alarm_pkg::OFS_STATUS, 32'h0);
            chk_w("status", {20'h0, 1'b1, rows[i].res, 2'b00, rows[i].code}, rd & 32'h0000_0FFF);
            if (rows[i].idx == alarm_pkg::IDX_GEAR) begin
                bus(1'b1, alarm_pkg::OFS_GEAR, 32'h0001_0001);
            end else begin
                ctrl.cause(rows[i].idx, 1'b0);
            end
            tick(2);
            chk_b("held", 1'b1, fault_output);
            if (i % 2 == 0) begin
                ctrl.pulse_reset(1'b0);
            end else begin
                bus(1'b1, alarm_pkg::OFS_CTRL, 32'h1);
            end
            tick(1);
            chk_b("after clear", ~rows[i].res, fault_output);
            if (!rows[i].res) begin
                power_cycle();
                tick(1);
                chk_b("after power cycle", 1'b0, fault_output);
            end else begin
                bus(1'b0, alarm_pkg::OFS_IRQ_STATUS, 32'h0);
                chk_w("irq events", 32'h3, rd);
                bus(1'b1, alarm_pkg::OFS_IRQ_STATUS, 32'h3);
                tick(2);
                chk_b("irq cleared", 1'b0, irq);
            end
            chk_w("code cleared", 32'h0, {24'h0, alarm_code});
        end
        // A clear with its cause present is refused; a later cause cannot replace the code.
        ctrl.cause(alarm_pkg::IDX_DEVIATION, 1'b1);
        tick(2);
        ctrl.cause(alarm_pkg::IDX_UNDERVOLT, 1'b1);
        ctrl.pulse_reset(1'b0);
        bus(1'b1, alarm_pkg::OFS_CTRL, 32'h1);
        tick(1);
        chk_b("refused clear", 1'b1, fault_output);
        chk_w("first code", 32'h18, {24'h0, alarm_code});
        chk_b("masked irq", 1'b0, irq);
        // Clearing with run held high restarts the stage at once.
        ctrl.cause(alarm_pkg::IDX_DEVIATION, 1'b0);
        ctrl.cause(alarm_pkg::IDX_UNDERVOLT, 1'b0);
        ctrl.set_run(1'b1);
        tick(2);
        chk_b("stage off", 1'b0, power_stage_en);
        ctrl.pulse_reset(1'b1);
        tick(1);
        chk_b("restart", 1'b1, power_stage_en);
        bus(1'b0, alarm_pkg::OFS_STATUS, 32'h0);
        chk_w("status running", 32'h0000_0700, rd);
        bus(1'b1, alarm_pkg::OFS_IRQ_MASK, 32'h3);
        tick(2);
        chk_b("unmasked irq", 1'b1, irq);
        bus(1'b1, alarm_pkg::OFS_IRQ_STATUS, 32'h3);
        tick(2);
        chk_b("irq dropped", 1'b0, irq);
        // A count equal to the threshold is no overflow.
        ctrl.set_dev(32'h0001_0000);
        tick(3);
        chk_b("at threshold", 1'b0, fault_output);
        chk_b("still running", 1'b1, power_stage_en);
        report_and_stop();
    end
endmodule // tb
